// >>> tlw_clkgen.sv
// Master shift-clock divider; idles high whenever it is not running.
`timescale 1ns/1ps
`default_nettype none
module tlw_clkgen (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       run,
  input  wire logic [8:0] half_cyc,
  output logic            sck
);

  logic [8:0] cnt_r;
  logic [8:0] cnt_nxt;
  logic       wrap;

  assign wrap    = (cnt_r == half_cyc - 9'h001);
  assign cnt_nxt = (!run || wrap) ? 9'h000 : cnt_r + 9'h001;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 9'h000;
      sck   <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      sck   <= !run ? 1'b1 : (wrap ? !sck : sck);
    end
  end

endmodule
`default_nettype wire

// >>> tlw_peer.sv
// Behavioural model of the external peer that clocks a slave transfer.
`timescale 1ns/1ps
`default_nettype none
module tlw_peer (
  input  wire logic       go,
  input  wire logic [7:0] tx,
  input  wire logic       so,
  output logic            sck,
  output logic            si,
  output logic [7:0]      rx
);
  initial begin
    sck = 1'b1;
    si = 1'b0;
    rx = 8'h00;
    forever begin
      @(posedge go);
      for (int i = 7; i >= 0; i--) begin
        #80 sck = 1'b0;
        si = tx[i];
        #80 sck = 1'b1;
        rx = {rx[6:0], so};
      end
      // Hold time over: the line no longer shows the last bit.
      #80 si = ~si;
    end
  end
endmodule
`default_nettype wire

// >>> tlw_pkg.sv
// Constants and carrier types shared by the three-wire serial port files.
package tlw_pkg;

  // Register map of the plain register port (word index = address).
  localparam int          ADDR_W    = 3;
  localparam int          DATA_W    = 8;
  localparam logic [2:0]  OFS_CTRL  = 3'h0;
  localparam logic [2:0]  OFS_SHIFT = 3'h1;
  localparam logic [2:0]  OFS_DIR   = 3'h2;
  localparam logic [2:0]  OFS_LATCH = 3'h3;

  // Control register, bits 3..0.
  typedef struct packed {
    logic clock_select_hi;
    logic clock_select_lo;
    logic serial_output_enable_flag;
    logic transfer_start_flag;
  } tlw_ctrl_s;

  // Pin direction flags, bits 2..0; a one makes the pin an output.
  typedef struct packed {
    logic clock_pin_direction;
    logic data_out_pin_direction;
    logic data_in_pin_direction;
  } tlw_dir_s;

  // General-purpose output latches of the three pins, bits 2..0.
  typedef struct packed {
    logic sck;
    logic so;
    logic si;
  } tlw_latch_s;

  localparam tlw_ctrl_s  CTRL_RST  = 4'h0;
  localparam tlw_dir_s   DIR_RST   = 3'h0;
  localparam tlw_latch_s LATCH_RST = 3'h4;
  localparam logic [7:0] SHIFT_RST = 8'h00;

  // Both clock-select flags high selects the peer's clock.
  localparam logic [1:0] CKS_SLAVE     = 2'h3;
  localparam logic [3:0] BITS_PER_XFER = 4'h8;

  // Master shift-clock half periods per clock-select value.
  localparam int         CLK_NS      = 5;
  localparam int         HALF_NS_0   = 400;
  localparam int         HALF_NS_1   = 800;
  localparam int         HALF_NS_2   = 1600;
  localparam logic [8:0] HALF_CYC_0  = 9'((HALF_NS_0 + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0] HALF_CYC_1  = 9'((HALF_NS_1 + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0] HALF_CYC_2  = 9'((HALF_NS_2 + CLK_NS - 1) / CLK_NS);

endpackage

// >>> tlw_serial.sv
// Three-wire serial port with wait block, clock counter and pin control.
//
// Operation
// - Wait state halts clock and shift register.
// - Writing start flag one begins transfer.
// - Eighth rising edge re-enters wait, clears flag.
// - Start flag reads back transfer in progress.
// - Writing zero forces wait, clears counter.
// - Wait-state loads work; MSB out on release.
// - Slave wait-state load with clock low loses contents.
// - Load with clock high: MSB at fall.
// - Load with clock low drives MSB immediately.
// - After eight pulses master clock stays high.
// - Clock selects pick mode; enable picks transmit.
// - Master drives clock pin when direction output.
// - Slave floats clock pin when direction input, peer clocks.
// - Transmit data changes on falling clock edge.
// - Receive samples data pin on rising edge.
// - Clock pin read: latch waiting, pin running.
// - Data-out pin read returns its latch.
// - Eight-bit register, MSB out, LSB in.
// - Reset, clock stop, chip-enable reset force wait.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tlw_serial (
  input  wire logic       CLK_SYS,
  input  wire logic       NRST,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       STOP_CLK,
  input  wire logic       CE_RST,
  input  wire logic       SCK_I,
  output logic            SCK_O,
  output logic            SCK_OE_N,
  output logic            SO_O,
  output logic            SO_OE_N,
  input  wire logic       SI_I,
  output logic            SI_O,
  output logic            SI_OE_N
);

  // Rotates the register left by one, MSB landing in the LSB.
  function automatic logic [7:0] rotl1(input logic [7:0] v);
    rotl1 = {v[6:0], v[7]};
  endfunction

  // True when the port index selects the given register.
  function automatic logic reg_hit(input logic [2:0] a,
                                   input logic [2:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  // Register state.
  tlw_pkg::tlw_ctrl_s  ctrl_r;
  tlw_pkg::tlw_ctrl_s  ctrl_nxt;
  tlw_pkg::tlw_dir_s   dir_r;
  tlw_pkg::tlw_dir_s   dir_nxt;
  tlw_pkg::tlw_latch_s latch_r;
  tlw_pkg::tlw_latch_s latch_nxt;
  logic [7:0]          sr_r;
  logic [7:0]          sr_nxt;
  logic [3:0]          cnt_r;
  logic [3:0]          cnt_nxt;
  logic                so_data_r;
  logic                so_data_nxt;
  logic                sck_prev_r;
  logic [7:0]          rdata_nxt;

  // Pin-side levels after synchronisation, and the internal master clock.
  logic [1:0]          pins_s;
  logic                sck_s;
  logic                si_s;
  logic                int_sck;

  // Decode and derived conditions.
  logic                busy;
  logic                is_master;
  logic                wr_ctrl;
  logic                wr_shift;
  logic                wr_dir;
  logic                wr_latch;
  logic                ts_wdata;
  logic                release_ev;
  logic                forced_wait;
  logic                global_wait;
  logic                sck_lvl;
  logic                sck_rise;
  logic                sck_fall;
  logic [3:0]          cnt_inc;
  logic                last_rise;
  logic                si_bit;
  logic                load_lost;
  logic [8:0]          half_cyc;
  logic [7:0]          ctrl_rd;
  logic [7:0]          shift_rd;
  logic [7:0]          latch_rd;
  logic [7:0]          rd_mux;
  logic [7:0]          dir_rd;
  logic                sck_o_nxt;
  logic                so_o_nxt;

  // Both pins come from outside the clock domain; nothing but the second
  // flop of the synchroniser is ever read.
  tlw_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk  (CLK_SYS),
    .nrst (NRST),
    .d    ({SCK_I, SI_I}),
    .q    (pins_s)
  );

  assign sck_s = pins_s[1];
  assign si_s  = pins_s[0];

  assign is_master = {ctrl_r.clock_select_hi, ctrl_r.clock_select_lo}
                     != tlw_pkg::CKS_SLAVE;
  assign busy      = ctrl_r.transfer_start_flag;

  assign half_cyc = ctrl_r.clock_select_hi ? tlw_pkg::HALF_CYC_2 :
                    ctrl_r.clock_select_lo ? tlw_pkg::HALF_CYC_1 :
                                             tlw_pkg::HALF_CYC_0;

  // The generator restarts from a full high half period, so every frame
  // opens with a falling edge and the first bit has a whole half to settle.
  // generator halted in wait
  tlw_clkgen u_clkgen (
    .clk      (CLK_SYS),
    .nrst     (NRST),
    .run      (busy && is_master),
    .half_cyc (half_cyc),
    .sck      (int_sck)
  );

  // Register port decode.
  assign wr_ctrl  = WR && reg_hit(ADDR, tlw_pkg::OFS_CTRL);
  assign wr_shift = WR && reg_hit(ADDR, tlw_pkg::OFS_SHIFT);
  assign wr_dir   = WR && reg_hit(ADDR, tlw_pkg::OFS_DIR);
  assign wr_latch = WR && reg_hit(ADDR, tlw_pkg::OFS_LATCH);
  assign ts_wdata = WDATA[0];

  assign release_ev  = wr_ctrl && ts_wdata && !busy;
  assign forced_wait = wr_ctrl && !ts_wdata;
  assign global_wait = STOP_CLK || CE_RST;

  // In slave mode the edge detector follows the peer clock all the time,
  // so the first edge after release is judged against a settled level.
  assign sck_lvl  = is_master ? int_sck : sck_s;
  assign sck_rise = busy && sck_lvl && !sck_prev_r;
  assign sck_fall = busy && !sck_lvl && sck_prev_r;

  assign cnt_inc   = cnt_r + 4'h1;
  assign last_rise = sck_rise && (cnt_inc == tlw_pkg::BITS_PER_XFER);

  assign si_bit = dir_r.data_in_pin_direction ? latch_r.si : si_s;

  // Lost contents read as zero; reload once the clock pin is high.
  // slave low-clock load lost
  assign load_lost = !is_master && !busy && !sck_s;

  // A software write of one beats the self-clear on the last edge, so a
  // restart issued in that very cycle is not dropped.
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = tlw_pkg::tlw_ctrl_s'(WDATA[3:0]);
    end else if (last_rise) begin
      ctrl_nxt.transfer_start_flag = 1'b0;
    end
    if (global_wait) begin
      ctrl_nxt.transfer_start_flag = 1'b0;
    end
  end

  always_comb begin
    cnt_nxt = cnt_r;
    if (global_wait || forced_wait || last_rise) begin
      cnt_nxt = 4'h0;
    end else if (sck_rise) begin
      cnt_nxt = cnt_inc;
    end
  end

  // A write while running is kept as written; the counter is left alone,
  // so a load with the clock high continues the current frame.
  always_comb begin
    sr_nxt = sr_r;
    if (wr_shift) begin
      sr_nxt = load_lost ? 8'h00 : WDATA;
    end else if (sck_rise) begin
      sr_nxt = {sr_r[6:0], si_bit};
    end
  end

  always_comb begin
    so_data_nxt = so_data_r;
    if (wr_shift && busy && !sck_lvl) begin
      so_data_nxt = WDATA[7];
    end else if (sck_fall) begin
      so_data_nxt = sr_r[7];
    end else if (release_ev) begin
      so_data_nxt = sr_r[7];
    end
  end

  assign dir_nxt   = wr_dir ? tlw_pkg::tlw_dir_s'(WDATA[2:0]) : dir_r;
  assign latch_nxt = wr_latch ? tlw_pkg::tlw_latch_s'(WDATA[2:0]) : latch_r;

  // Readback.
  // start flag shows busy
  assign ctrl_rd  = {4'h0, ctrl_r};
  assign shift_rd = (is_master && busy && sck_lvl) ? rotl1(sr_r) : sr_r;
  assign latch_rd = {5'h00,
                     busy ? sck_s : latch_r.sck,
                     latch_r.so,
                     si_bit};

  assign dir_rd = {5'h00, dir_r};

  assign rd_mux = reg_hit(ADDR, tlw_pkg::OFS_CTRL)  ? ctrl_rd  :
                  reg_hit(ADDR, tlw_pkg::OFS_SHIFT) ? shift_rd :
                  reg_hit(ADDR, tlw_pkg::OFS_DIR)   ? dir_rd   :
                  reg_hit(ADDR, tlw_pkg::OFS_LATCH) ? latch_rd : 8'h00;

  // Read data is zero outside its cycle, so a stale word can never be
  // mistaken for the answer to a later read.
  assign rdata_nxt = RD ? rd_mux : 8'h00;

  assign sck_o_nxt = is_master ? (busy ? int_sck : 1'b1) : latch_r.sck;
  assign so_o_nxt  = (ctrl_r.serial_output_enable_flag && busy) ?
                     so_data_r : latch_r.so;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ctrl_r     <= tlw_pkg::CTRL_RST;
      dir_r      <= tlw_pkg::DIR_RST;
      latch_r    <= tlw_pkg::LATCH_RST;
      sr_r       <= tlw_pkg::SHIFT_RST;
      cnt_r      <= 4'h0;
      so_data_r  <= 1'b0;
      sck_prev_r <= 1'b1;
      RDATA      <= 8'h00;
    end else begin
      ctrl_r     <= ctrl_nxt;
      dir_r      <= dir_nxt;
      latch_r    <= latch_nxt;
      sr_r       <= sr_nxt;
      cnt_r      <= cnt_nxt;
      so_data_r  <= so_data_nxt;
      sck_prev_r <= sck_lvl;
      RDATA      <= rdata_nxt;
    end
  end

  // Pin drivers, each registered so the pads never see decode glitches.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      SCK_O    <= 1'b1;
      SCK_OE_N <= 1'b1;
      SO_O     <= 1'b0;
      SO_OE_N  <= 1'b1;
      SI_O     <= 1'b0;
      SI_OE_N  <= 1'b1;
    end else begin
      SCK_O    <= sck_o_nxt;
      SCK_OE_N <= !dir_r.clock_pin_direction;
      SO_O     <= so_o_nxt;
      SO_OE_N  <= !dir_r.data_out_pin_direction;
      SI_O     <= latch_r.si;
      SI_OE_N  <= !dir_r.data_in_pin_direction;
    end
  end

endmodule
`default_nettype wire

// >>> tlw_serial_properties.sv
// Port-level assertions for the three-wire serial port.
`timescale 1ns/1ps
`default_nettype none
module tlw_serial_properties (
  input wire logic       CLK_SYS,
  input wire logic       NRST,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       STOP_CLK,
  input wire logic       CE_RST,
  input wire logic       SCK_I,
  input wire logic       SCK_O,
  input wire logic       SCK_OE_N,
  input wire logic       SO_O,
  input wire logic       SO_OE_N,
  input wire logic       SI_I,
  input wire logic       SI_O,
  input wire logic       SI_OE_N
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  a_rdata_one_cycle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside its cycle");
  a_sck_dir_drive: assert property (WR && ADDR == tlw_pkg::OFS_DIR
    |-> ##2 SCK_OE_N == !$past(WDATA[2], 2))
    else $error("clock pin enable wrong");
  a_so_dir_drive: assert property (WR && ADDR == tlw_pkg::OFS_DIR
    |-> ##2 SO_OE_N == !$past(WDATA[1], 2))
    else $error("data out enable wrong");
  a_si_dir_float: assert property (WR && ADDR == tlw_pkg::OFS_DIR
    |-> ##2 SI_OE_N == !$past(WDATA[0], 2))
    else $error("data in enable wrong");
  // Slowest master half period is 320 cycles.
  a_sck_low_bound: assert property ($fell(SCK_O) |-> ##[1:330] SCK_O)
    else $error("shift clock stuck low");
  a_stop_idles_sck: assert property (STOP_CLK |-> ##[1:4] SCK_O)
    else $error("clock stop left clock low");
  a_ce_idles_sck: assert property (CE_RST [*4] |-> SCK_O)
    else $error("chip reset left clock low");
  a_forced_wait_flag: assert property (
    WR && ADDR == tlw_pkg::OFS_CTRL && !WDATA[0] ##2
    RD && ADDR == tlw_pkg::OFS_CTRL |=> !RDATA[0])
    else $error("start flag survived a zero write");
  c_sck_fall: cover property ($fell(SCK_O));
  c_stop: cover property (STOP_CLK);
  c_ce: cover property (CE_RST [*4]);
endmodule
`default_nettype wire

// >>> tlw_serial_test.sv
// Self-checking bench for the three-wire serial port.
`timescale 1ns/1ps
`default_nettype none
module tlw_serial_test;
  logic            clk = 1'b0;
  logic            nrst = 1'b0;
  logic [2:0]      addr = 3'h0;
  logic [7:0]      wdata = 8'h00;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic            stop = 1'b0;
  logic            ce = 1'b0;
  logic            go = 1'b0;
  logic            loop = 1'b0;
  logic [7:0]      tx = 8'h00;
  logic [7:0]      d;
  int              bad_count = 0;
  int              n_tests = 0;
  wire logic [7:0] rdata;
  wire logic [7:0] rx;
  wire logic       sck_o, sck_oe_n, so_o, so_oe_n, si_o, si_oe_n;
  wire logic       p_sck, p_si, sck_w, so_w, si_w;
  // Master mode loops data out back to data in; the data line has a pull-up.
  assign sck_w = sck_oe_n ? p_sck : sck_o;
  assign so_w = so_oe_n ? 1'b1 : so_o;
  assign si_w = si_oe_n ? (loop ? so_w : p_si) : si_o;
  always #2.5 clk = ~clk;
  tlw_serial DUT (.CLK_SYS(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .STOP_CLK(stop), .CE_RST(ce),
    .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE_N(sck_oe_n), .SO_O(so_o),
    .SO_OE_N(so_oe_n), .SI_I(si_w), .SI_O(si_o), .SI_OE_N(si_oe_n));
  tlw_peer peer (.go(go), .tx(tx), .so(so_w), .sck(p_sck), .si(p_si),
    .rx(rx));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [2:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    rd_reg(a);
    chk(d, exp);
  endtask
  // Bounded wait for the start flag to drop.
  task automatic poll;
    for (int i = 0; i < 1000; i++) begin
      rd_reg(tlw_pkg::OFS_CTRL);
      if (d[0] === 1'b0) break;
    end
    chk({7'h0, d[0]}, 8'h00);
  endtask
  task automatic results;
    $display("Mismatches %0d in %0d checks", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    results();
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc(tlw_pkg::OFS_CTRL, 8'h00);
    rdc(tlw_pkg::OFS_DIR, 8'h00);
    rdc(tlw_pkg::OFS_LATCH, 8'h04);
    wr_reg(3'h5, 8'hff);
    rdc(3'h5, 8'h00);
    loop <= 1'b1;
    wr_reg(tlw_pkg::OFS_DIR, 8'h06);
    wr_reg(tlw_pkg::OFS_SHIFT, 8'ha5);
    rdc(tlw_pkg::OFS_SHIFT, 8'ha5);
    wr_reg(tlw_pkg::OFS_CTRL, 8'h03);
    rdc(tlw_pkg::OFS_CTRL, 8'h03);
    chk({7'h0, so_o}, 8'h01);
    poll();
    rdc(tlw_pkg::OFS_SHIFT, 8'ha5);
    chk({7'h0, sck_o}, 8'h01);
    // Two bits shifted, abort, then a full eight: rotated left by two.
    wr_reg(tlw_pkg::OFS_SHIFT, 8'h3c);
    wr_reg(tlw_pkg::OFS_CTRL, 8'h03);
    repeat (2) @(posedge sck_o);
    rdc(tlw_pkg::OFS_SHIFT, 8'he1);
    wr_reg(tlw_pkg::OFS_CTRL, 8'h02);
    rdc(tlw_pkg::OFS_CTRL, 8'h02);
    wr_reg(tlw_pkg::OFS_CTRL, 8'h03);
    poll();
    rdc(tlw_pkg::OFS_SHIFT, 8'hf0);
    wr_reg(tlw_pkg::OFS_SHIFT, 8'h00);
    wr_reg(tlw_pkg::OFS_CTRL, 8'h03);
    @(negedge sck_o);
    wr_reg(tlw_pkg::OFS_SHIFT, 8'h80);
    @(posedge clk);
    #1;
    chk({7'h0, so_o}, 8'h01);
    // A load with the clock high waits for the next fall to show its MSB.
    @(posedge sck_o);
    wr_reg(tlw_pkg::OFS_SHIFT, 8'h00);
    chk({7'h0, so_o}, 8'h01);
    @(negedge sck_o);
    repeat (2) @(posedge clk);
    chk({7'h0, so_o}, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr_reg(tlw_pkg::OFS_CTRL, 8'h03);
      @(posedge sck_o);
      stop <= (i == 0);
      ce <= (i == 1);
      @(posedge clk);
      stop <= 1'b0;
      repeat (3) @(posedge clk);
      ce <= 1'b0;
      @(posedge clk);
      rdc(tlw_pkg::OFS_CTRL, 8'h02);
    end
    loop <= 1'b0;
    wr_reg(tlw_pkg::OFS_DIR, 8'h02);
    wr_reg(tlw_pkg::OFS_SHIFT, 8'hc3);
    wr_reg(tlw_pkg::OFS_CTRL, 8'h0f);
    tx <= 8'h5a;
    go <= 1'b1;
    poll();
    rdc(tlw_pkg::OFS_SHIFT, 8'h5a);
    chk(rx, 8'hc3);
    chk({7'h0, sck_oe_n}, 8'h01);
    // Slave in wait with the clock pin pulled low: a load is lost.
    wr_reg(tlw_pkg::OFS_DIR, 8'h07);
    wr_reg(tlw_pkg::OFS_LATCH, 8'h02);
    repeat (3) @(posedge clk);
    wr_reg(tlw_pkg::OFS_SHIFT, 8'h55);
    rdc(tlw_pkg::OFS_SHIFT, 8'h00);
    wr_reg(tlw_pkg::OFS_DIR, 8'h03);
    wr_reg(tlw_pkg::OFS_LATCH, 8'h06);
    rdc(tlw_pkg::OFS_LATCH, 8'h06);
    chk({7'h0, so_o}, 8'h01);
    wr_reg(tlw_pkg::OFS_LATCH, 8'h07);
    rdc(tlw_pkg::OFS_LATCH, 8'h07);
    chk({7'h0, si_o}, 8'h01);
    results();
  end
endmodule
bind tlw_serial tlw_serial_properties u_props (.CLK_SYS(CLK_SYS),
  .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .STOP_CLK(STOP_CLK), .CE_RST(CE_RST), .SCK_I(SCK_I),
  .SCK_O(SCK_O), .SCK_OE_N(SCK_OE_N), .SO_O(SO_O), .SO_OE_N(SO_OE_N),
  .SI_I(SI_I), .SI_O(SI_O), .SI_OE_N(SI_OE_N));
`default_nettype wire

// >>> tlw_sync.sv
// Two-flop synchroniser for pin levels entering the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module tlw_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule
`default_nettype wire
